/* rtl/etc_params.svh */
// Constants of the Ethernet traffic controller
`ifndef ETC_PARAMS_SVH
`define ETC_PARAMS_SVH
`define ETC_DATA_W 64
`define ETC_FIFO_DEPTH 512
`define ETC_FIFO_AW 9
`define ETC_FIFO_MARGIN 10'h008
`define ETC_ADDR_W 8
`define ETC_OFS_TOTAL 8'h00
`define ETC_OFS_RANDLEN 8'h04
`define ETC_OFS_RANDPAY 8'h08
`define ETC_OFS_MAXLEN 8'h0c
`define ETC_OFS_CTRL 8'h10
`define ETC_OFS_EXPECT 8'h14
`define ETC_OFS_STATUS 8'h18
`define ETC_OFS_SENT 8'h1c
`define ETC_OFS_GOOD 8'h20
`define ETC_OFS_BAD 8'h24
`define ETC_OFS_WORDS 8'h28
`define ETC_OFS_CYCLES 8'h2c
`define ETC_OFS_INTSTS 8'h30
`define ETC_OFS_INTMSK 8'h34
`define ETC_RST_TOTAL 32'h0000_0000
`define ETC_RST_MAXLEN 16'h0010
`define ETC_RST_LFSR 32'h1234_5679
`define ETC_CTRL_START 0
`define ETC_CTRL_DROP 1
`define ETC_INT_GEN 0
`define ETC_INT_MON 1
`define ETC_INT_BAD 2
`define ETC_CLK_MHZ 100
`define ETC_BLINK_MS 250
`endif

/* rtl/etc_pkg.sv */
// Types of the Ethernet traffic controller
`include "etc_params.svh"
package etc_pkg;
  typedef struct packed {
    logic [`ETC_DATA_W-1:0] data;
    logic sop;
    logic eop;
    logic err;
  } etc_beat_t;
  typedef enum logic [1:0] {
    ETC_GEN_IDLE = 2'b00,
    ETC_GEN_SEND = 2'b01,
    ETC_GEN_DONE = 2'b10
  } etc_gen_st_t;
endpackage

/* rtl/etc_top.sv */
// Traffic generator, monitor and packet FIFOs with register port
//
// Added by the designer: the register addresses and strobed register access.
`include "etc_params.svh"
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Store-and-forward packet FIFO
module etc_fifo
  import etc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic drop_en, // Discard errored packets
  input wire etc_beat_t in_beat, // Write beat
  input wire logic in_valid, // Write valid
  output logic in_ready, // Write ready, registered
  output etc_beat_t out_beat, // Read beat, registered
  output logic out_valid, // Read valid
  input wire logic out_ready // Read ready
);
  etc_beat_t mem [`ETC_FIFO_DEPTH];
  logic [`ETC_FIFO_AW:0] wr_ptr, wr_commit, rd_ptr, pkt_cnt, used;
  logic pkt_err;
  logic [`ETC_FIFO_AW:0] next_wr_ptr, next_wr_commit, next_rd_ptr, next_pkt_cnt;
  logic next_pkt_err, next_in_ready, next_out_valid, wr_fire, pop, drop;
  etc_beat_t next_out_beat;
  always_comb begin
    used = wr_ptr - rd_ptr;
    wr_fire = in_valid && in_ready;
    pop = (!out_valid || out_ready) && (pkt_cnt != '0);
    drop = drop_en && (in_beat.err || pkt_err);
    next_wr_ptr = wr_ptr;
    next_wr_commit = wr_commit;
    next_pkt_err = pkt_err;
    next_pkt_cnt = pkt_cnt;
    next_rd_ptr = rd_ptr;
    next_out_beat = out_beat;
    next_out_valid = out_valid && !out_ready;
    if (wr_fire) begin
      next_wr_ptr = wr_ptr + 1'b1;
      next_pkt_err = pkt_err || in_beat.err;
      if (in_beat.eop) begin
        next_pkt_err = 1'b0;
        if (drop) begin
          next_wr_ptr = wr_commit;
        end else begin
          next_wr_commit = wr_ptr + 1'b1;
          next_pkt_cnt = next_pkt_cnt + 1'b1;
        end
      end
    end
    if (pop) begin
      next_out_beat = mem[rd_ptr[`ETC_FIFO_AW-1:0]];
      next_out_valid = 1'b1;
      next_rd_ptr = rd_ptr + 1'b1;
      if (next_out_beat.eop) begin
        next_pkt_cnt = next_pkt_cnt - 1'b1;
      end
    end
    next_in_ready = (next_wr_ptr - next_rd_ptr) < (10'(`ETC_FIFO_DEPTH) - `ETC_FIFO_MARGIN);
  end
  always_ff @(posedge clk) begin
    if (wr_fire) begin
      mem[wr_ptr[`ETC_FIFO_AW-1:0]] <= in_beat;
    end
    if (rst) begin
      wr_ptr <= '0;
      wr_commit <= '0;
      rd_ptr <= '0;
      pkt_cnt <= '0;
      pkt_err <= 1'b0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_beat <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      wr_commit <= next_wr_commit;
      rd_ptr <= next_rd_ptr;
      pkt_cnt <= next_pkt_cnt;
      pkt_err <= next_pkt_err;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
      out_beat <= next_out_beat;
    end
  end
  AST_COMMIT_ONLY: assert property (@(posedge clk) disable iff (rst) pkt_cnt <= used)
    else $error("more complete packets than stored words");
  AST_DROP_REWIND: assert property (@(posedge clk) disable iff (rst)
    wr_fire && in_beat.eop && drop |=> wr_ptr == $past(wr_commit) && pkt_cnt <= $past(pkt_cnt))
    else $error("errored packet not discarded");
endmodule
// ==========================================================
module etc_top
  import etc_pkg::*;
#(
  parameter int BLINK_CYCLES = `ETC_BLINK_MS * `ETC_CLK_MHZ * 1000
) (
  input wire logic CLK, // Clock
  input wire logic RST, // Sync reset
  input wire logic [`ETC_ADDR_W-1:0] ADDR, // Register address
  input wire logic [31:0] WDATA, // Write data
  input wire logic WE, // Write strobe
  input wire logic RE, // Read strobe
  output logic [31:0] RDATA, // Read data
  output logic [`ETC_DATA_W-1:0] TX_DATA, // To MAC transmit
  output logic TX_VALID, // Transmit valid
  output logic TX_SOP, // Transmit start of packet
  output logic TX_EOP, // Transmit end of packet
  input wire logic TX_READY, // MAC transmit ready
  input wire logic [`ETC_DATA_W-1:0] RX_DATA, // From MAC receive
  input wire logic RX_VALID, // Receive valid
  input wire logic RX_SOP, // Receive start of packet
  input wire logic RX_EOP, // Receive end of packet
  input wire logic RX_ERR, // Receive error mark
  output logic RX_READY, // Receive ready
  output logic IRQ, // Interrupt
  output logic LED // Test status
);
  logic [31:0] total_packet_count, expect_cnt, sent, good, bad, words, cycles, lfsr, blink_cnt;
  logic random_length_enable, random_payload, drop_en, mon_run, mon_fin, led, irq;
  logic [15:0] max_packet_length, glen, widx;
  logic [63:0] pat;
  logic [2:0] int_sts, int_msk;
  logic [31:0] rdata;
  etc_gen_st_t gst;
  etc_beat_t gen_beat, txo, rx_beat, mono;
  logic gen_ready, tx_out_valid, mono_valid, rx_ready_q, start, gen_fire;
  logic [31:0] next_total, next_expect, next_sent, next_good, next_bad, next_words, next_cycles;
  logic [31:0] next_lfsr, next_rdata, next_blink;
  logic next_rlen, next_rpay, next_drop, next_run, next_fin, next_led, next_irq, mon_pkt_err, next_pkt_err;
  logic [15:0] next_maxlen, next_glen, next_widx;
  logic [63:0] next_pat;
  logic [2:0] next_sts, next_msk, ev;
  etc_gen_st_t next_gst;
  function automatic logic [15:0] pick_len(input logic [31:0] r, input logic [15:0] m, input logic rnd);
    logic [15:0] mx;
    mx = (m == 16'h0000) ? 16'h0001 : m;
    if (rnd && r[15:0] != 16'h0000 && r[15:0] <= mx) begin
      pick_len = r[15:0];
    end else begin
      pick_len = mx;
    end
  endfunction
  // ==========================================================
  // FIFOs
  etc_fifo u_tx_fifo (
    .clk(CLK), .rst(RST), .drop_en(1'b0), .in_beat(gen_beat), .in_valid(gst == ETC_GEN_SEND),
    .in_ready(gen_ready), .out_beat(txo), .out_valid(tx_out_valid), .out_ready(TX_READY)
  );
  etc_fifo u_rx_fifo (
    .clk(CLK), .rst(RST), .drop_en(drop_en), .in_beat(rx_beat), .in_valid(RX_VALID),
    .in_ready(rx_ready_q), .out_beat(mono), .out_valid(mono_valid), .out_ready(1'b1)
  );
  always_comb begin
    rx_beat = '{data: RX_DATA, sop: RX_SOP, eop: RX_EOP, err: RX_ERR};
    TX_DATA = txo.data;
    TX_SOP = txo.sop;
    TX_EOP = txo.eop;
    TX_VALID = tx_out_valid;
    RX_READY = rx_ready_q;
  end
  // ==========================================================
  // Registers, generator, monitor
  always_comb begin
    start = WE && ADDR == `ETC_OFS_CTRL && WDATA[`ETC_CTRL_START];
    gen_fire = gst == ETC_GEN_SEND && gen_ready;
    gen_beat.data = random_payload ? {lfsr, ~lfsr} : pat;
    gen_beat.sop = widx == 16'h0000;
    gen_beat.eop = widx == glen - 16'h0001;
    gen_beat.err = 1'b0;
    next_total = total_packet_count;
    next_rlen = random_length_enable;
    next_rpay = random_payload;
    next_maxlen = max_packet_length;
    next_drop = drop_en;
    next_expect = expect_cnt;
    next_msk = int_msk;
    if (WE) begin
      case (ADDR)
        `ETC_OFS_TOTAL: next_total = WDATA;
        `ETC_OFS_RANDLEN: next_rlen = WDATA[0];
        `ETC_OFS_RANDPAY: next_rpay = WDATA[0];
        `ETC_OFS_MAXLEN: next_maxlen = WDATA[15:0];
        `ETC_OFS_CTRL: next_drop = WDATA[`ETC_CTRL_DROP];
        `ETC_OFS_EXPECT: next_expect = WDATA;
        `ETC_OFS_INTMSK: next_msk = WDATA[2:0];
        default: next_total = total_packet_count;
      endcase
    end
    next_gst = gst;
    next_sent = sent;
    next_widx = widx;
    next_pat = pat;
    next_glen = glen;
    next_lfsr = lfsr;
    ev = 3'b000;
    case (gst)
      ETC_GEN_IDLE, ETC_GEN_DONE: begin
        if (start) begin
          next_sent = 32'h0000_0000;
          next_widx = 16'h0000;
          next_glen = pick_len(lfsr, next_maxlen, next_rlen);
          next_gst = (next_total == 32'h0000_0000) ? ETC_GEN_DONE : ETC_GEN_SEND;
        end
      end
      ETC_GEN_SEND: begin
        if (gen_fire) begin
          next_lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
          next_pat = pat + 64'h1;
          next_widx = widx + 16'h0001;
          if (gen_beat.eop) begin
            next_sent = sent + 32'h1;
            next_widx = 16'h0000;
            next_glen = pick_len(next_lfsr, max_packet_length, random_length_enable);
            if (next_sent == total_packet_count) begin
              next_gst = ETC_GEN_DONE;
              ev[`ETC_INT_GEN] = 1'b1;
            end
          end
        end
      end
      default: next_gst = ETC_GEN_IDLE;
    endcase
    next_good = good;
    next_bad = bad;
    next_words = words;
    next_cycles = cycles;
    next_run = mon_run;
    next_fin = mon_fin;
    next_pkt_err = mon_pkt_err;
    if (start) begin
      next_good = 32'h0;
      next_bad = 32'h0;
      next_words = 32'h0;
      next_cycles = 32'h0;
      next_run = 1'b1;
      next_fin = 1'b0;
    end else if (mon_run) begin
      next_cycles = cycles + 32'h1;
      if (mono_valid) begin
        next_words = words + 32'h1;
        next_pkt_err = mon_pkt_err || mono.err;
        if (mono.eop) begin
          next_pkt_err = 1'b0;
          if (mon_pkt_err || mono.err) begin
            next_bad = bad + 32'h1;
            ev[`ETC_INT_BAD] = 1'b1;
          end else begin
            next_good = good + 32'h1;
          end
        end
      end
    end
    if (next_run && next_good + next_bad == next_expect) begin
      next_run = 1'b0;
      next_fin = 1'b1;
      ev[`ETC_INT_MON] = 1'b1;
    end
    next_blink = blink_cnt;
    next_led = 1'b0;
    if (mon_run || gst == ETC_GEN_SEND) begin
      next_blink = (blink_cnt >= 32'(BLINK_CYCLES - 1)) ? 32'h0 : blink_cnt + 32'h1;
      next_led = (blink_cnt == 32'h0) ? !led : led;
    end else begin
      next_led = mon_fin && bad == 32'h0;
    end
    next_sts = int_sts;
    if (WE && ADDR == `ETC_OFS_INTSTS) begin
      next_sts = int_sts & ~WDATA[2:0];
    end
    next_sts = next_sts | ev;
    next_irq = |(next_sts & next_msk);
    next_rdata = 32'h0;
    if (RE) begin
      case (ADDR)
        `ETC_OFS_TOTAL: next_rdata = total_packet_count;
        `ETC_OFS_RANDLEN: next_rdata = {31'h0, random_length_enable};
        `ETC_OFS_RANDPAY: next_rdata = {31'h0, random_payload};
        `ETC_OFS_MAXLEN: next_rdata = {16'h0, max_packet_length};
        `ETC_OFS_CTRL: next_rdata = {30'h0, drop_en, 1'b0};
        `ETC_OFS_EXPECT: next_rdata = expect_cnt;
        `ETC_OFS_STATUS: next_rdata = {27'h0, mon_run, mon_fin && bad != 32'h0, mon_fin && bad == 32'h0,
                                       mon_fin, gst == ETC_GEN_DONE};
        `ETC_OFS_SENT: next_rdata = sent;
        `ETC_OFS_GOOD: next_rdata = good;
        `ETC_OFS_BAD: next_rdata = bad;
        `ETC_OFS_WORDS: next_rdata = words;
        `ETC_OFS_CYCLES: next_rdata = cycles;
        `ETC_OFS_INTSTS: next_rdata = {29'h0, int_sts};
        `ETC_OFS_INTMSK: next_rdata = {29'h0, int_msk};
        default: next_rdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      total_packet_count <= `ETC_RST_TOTAL;
      random_length_enable <= 1'b0;
      random_payload <= 1'b0;
      max_packet_length <= `ETC_RST_MAXLEN;
      drop_en <= 1'b0;
      expect_cnt <= 32'h0;
      int_msk <= 3'h0;
      int_sts <= 3'h0;
      gst <= ETC_GEN_IDLE;
      sent <= 32'h0;
      widx <= 16'h0;
      pat <= 64'h0;
      glen <= `ETC_RST_MAXLEN;
      lfsr <= `ETC_RST_LFSR;
      good <= 32'h0;
      bad <= 32'h0;
      words <= 32'h0;
      cycles <= 32'h0;
      mon_run <= 1'b0;
      mon_fin <= 1'b0;
      mon_pkt_err <= 1'b0;
      blink_cnt <= 32'h0;
      led <= 1'b0;
      irq <= 1'b0;
      rdata <= 32'h0;
    end else begin
      total_packet_count <= next_total;
      random_length_enable <= next_rlen;
      random_payload <= next_rpay;
      max_packet_length <= next_maxlen;
      drop_en <= next_drop;
      expect_cnt <= next_expect;
      int_msk <= next_msk;
      int_sts <= next_sts;
      gst <= next_gst;
      sent <= next_sent;
      widx <= next_widx;
      pat <= next_pat;
      glen <= next_glen;
      lfsr <= next_lfsr;
      good <= next_good;
      bad <= next_bad;
      words <= next_words;
      cycles <= next_cycles;
      mon_run <= next_run;
      mon_fin <= next_fin;
      mon_pkt_err <= next_pkt_err;
      blink_cnt <= next_blink;
      led <= next_led;
      irq <= next_irq;
      rdata <= next_rdata;
    end
  end
  always_comb begin
    RDATA = rdata;
    LED = led;
    IRQ = irq;
  end
  // ==========================================================
  // Checks
  AST_GEN_STOP: assert property (@(posedge CLK) disable iff (RST)
    $rose(gst == ETC_GEN_DONE) |-> sent == total_packet_count)
    else $error("generator done with wrong count");
  AST_SOP: assert property (@(posedge CLK) disable iff (RST)
    TX_VALID && TX_READY && TX_EOP |=> !TX_VALID || TX_SOP)
    else $error("first beat lacks start mark");
  AST_LEN: assert property (@(posedge CLK) disable iff (RST)
    gst == ETC_GEN_SEND && max_packet_length != 16'h0 |-> glen <= max_packet_length && glen != 16'h0)
    else $error("packet length above maximum");
  AST_INC: assert property (@(posedge CLK) disable iff (RST)
    gen_fire && !random_payload ##1 gen_fire && !random_payload |-> gen_beat.data == $past(gen_beat.data) + 64'h1)
    else $error("payload pattern not incrementing");
  AST_MON_FIN: assert property (@(posedge CLK) disable iff (RST) $rose(mon_fin) |-> good + bad == expect_cnt)
    else $error("monitor finished at wrong count");
  AST_TPUT: assert property (@(posedge CLK) disable iff (RST)
    mon_run && !start ##1 mon_run |-> cycles == $past(cycles) + 32'h1)
    else $error("throughput cycle count stalled");
  AST_BAD: assert property (@(posedge CLK) disable iff (RST)
    mon_run && !start && mono_valid && mono.eop && mono.err |=> bad == $past(bad) + 32'h1 && int_sts[2])
    else $error("bad packet not counted");
  AST_PASS: assert property (@(posedge CLK) disable iff (RST)
    mon_fin && !mon_run && gst != ETC_GEN_SEND ##1 mon_fin && !mon_run && gst != ETC_GEN_SEND
    |-> LED == (bad == 32'h0))
    else $error("status light wrong after test");
  AST_TOTAL: assert property (@(posedge CLK) disable iff (RST)
    WE && ADDR == `ETC_OFS_TOTAL |=> total_packet_count == $past(WDATA))
    else $error("packet count write lost");
  COV_BURST: cover property (@(posedge CLK) disable iff (RST) $rose(gst == ETC_GEN_DONE));
  COV_PASS: cover property (@(posedge CLK) disable iff (RST) $rose(mon_fin) && bad == 32'h0);
  COV_FAIL: cover property (@(posedge CLK) disable iff (RST) $rose(mon_fin) && bad != 32'h0);
endmodule
`default_nettype wire

/* tb/etc_mac_model.sv */
// Loopback model of the MAC client ports: sinks transmit beats, returns them on receive
`include "etc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module etc_mac_model
  import etc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic [`ETC_DATA_W-1:0] tx_data, // Transmit data
  input wire logic tx_valid, // Transmit valid
  input wire logic tx_sop, // Transmit start of packet
  input wire logic tx_eop, // Transmit end of packet
  output logic tx_ready, // Transmit ready
  output logic [`ETC_DATA_W-1:0] rx_data, // Receive data
  output logic rx_valid, // Receive valid
  output logic rx_sop, // Receive start of packet
  output logic rx_eop, // Receive end of packet
  output logic rx_err, // Receive error mark
  input wire logic rx_ready, // Receive ready
  input wire logic err_en // Mark returned beats as errored
);
  etc_beat_t q[$];
  logic [`ETC_DATA_W-1:0] dq[$];
  int lens[$];
  int n = 0;
  etc_beat_t b;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = '0;
    rx_sop = 1'b0;
    rx_eop = 1'b0;
    rx_err = 1'b0;
  end
  // ==========================================================
  // Take and log transmit beats, stall at random
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      n = tx_sop ? 1 : n + 1;
      dq.push_back(tx_data);
      if (tx_eop) lens.push_back(n);
      q.push_back('{tx_data, tx_sop, tx_eop, err_en});
    end
    tx_ready <= ($urandom % 4) != 0;
    // Hold each beat until taken; idle lines toggle so stale data is never seen
    if (!rx_valid || rx_ready) begin
      if (q.size() > 0 && ($urandom % 3) != 0) begin
        b = q.pop_front();
        rx_valid <= 1'b1;
        rx_data <= b.data;
        rx_sop <= b.sop;
        rx_eop <= b.eop;
        rx_err <= b.err;
      end else begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        rx_sop <= ~rx_sop;
        rx_eop <= ~rx_eop;
        rx_err <= ~rx_err;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/etc_top_tb.sv */
// Self-checking bench of the Ethernet traffic controller
`include "etc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module etc_top_tb;
  logic CLK = 1'b0, RST = 1'b1, WE = 1'b0, RE = 1'b0, err_en = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000, RDATA, rv;
  logic [63:0] TX_DATA, RX_DATA, cnt = 64'h0;
  logic TX_VALID, TX_SOP, TX_EOP, TX_READY, RX_VALID, RX_SOP, RX_EOP, RX_ERR, RX_READY, IRQ, LED;
  int n_errors = 0, compares = 0, cyc = 0, i, k, w;
  etc_top #(.BLINK_CYCLES(4)) i_etc_top (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WE(WE), .RE(RE),
    .RDATA(RDATA), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_SOP(TX_SOP), .TX_EOP(TX_EOP),
    .TX_READY(TX_READY), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_SOP(RX_SOP), .RX_EOP(RX_EOP),
    .RX_ERR(RX_ERR), .RX_READY(RX_READY), .IRQ(IRQ), .LED(LED));
  etc_mac_model i_etc_mac_model (.clk(CLK), .tx_data(TX_DATA), .tx_valid(TX_VALID), .tx_sop(TX_SOP),
    .tx_eop(TX_EOP), .tx_ready(TX_READY), .rx_data(RX_DATA), .rx_valid(RX_VALID), .rx_sop(RX_SOP),
    .rx_eop(RX_EOP), .rx_err(RX_ERR), .rx_ready(RX_READY), .err_en(err_en));
  always #5 CLK = ~CLK;
  // ==========================================================
  // Checking and register bus tasks
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WE <= 1'b1;
    @(posedge CLK);
    WE <= 1'b0;
    @(posedge CLK);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ADDR <= a;
    RE <= 1'b1;
    @(posedge CLK);
    RE <= 1'b0;
    @(posedge CLK);
    d = RDATA;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a, rv);
    chk(nm, e, rv);
  endtask
  // ==========================================================
  // One burst: configure, start, wait, then compare with the bench model
  task automatic run(input int tot, input int len, input bit rl, input bit rp, input bit er, input bit dr);
    err_en <= er;
    wr(`ETC_OFS_TOTAL, 32'(tot));
    wr(`ETC_OFS_RANDLEN, {31'h0, rl});
    wr(`ETC_OFS_RANDPAY, {31'h0, rp});
    wr(`ETC_OFS_MAXLEN, 32'(len));
    wr(`ETC_OFS_EXPECT, 32'(tot));
    rc(`ETC_OFS_TOTAL, 32'(tot), "total count");
    wr(`ETC_OFS_CTRL, {30'h0, dr, 1'b1});
    for (i = 0; i < 400; i++) begin
      rd(`ETC_OFS_STATUS, rv);
      if (rv[0] && (rv[1] || (er && dr && i_etc_mac_model.lens.size() == tot &&
          i_etc_mac_model.q.size() == 0 && !RX_VALID))) break;
    end
    chk("generator done", 1, rv[0]);
    chk("packets sent", tot, i_etc_mac_model.lens.size());
    rc(`ETC_OFS_SENT, 32'(tot), "sent count");
    w = 0;
    for (k = 0; k < i_etc_mac_model.lens.size(); k++) begin
      w += i_etc_mac_model.lens[k];
      if (rl) chk("length in range", 1, i_etc_mac_model.lens[k] >= 1 && i_etc_mac_model.lens[k] <= len);
      else chk("length", len, i_etc_mac_model.lens[k]);
    end
    for (k = 0; k < i_etc_mac_model.dq.size(); k++) begin
      if (rp) begin
        chk("random word", i_etc_mac_model.dq[k][63:32], 32'(~i_etc_mac_model.dq[k][31:0]));
      end else begin
        chk("payload", cnt, i_etc_mac_model.dq[k]);
        cnt++;
      end
    end
    if (er && dr) begin
      rc(`ETC_OFS_GOOD, 0, "good dropped");
      rc(`ETC_OFS_BAD, 0, "bad dropped");
      rd(`ETC_OFS_STATUS, rv);
      chk("monitor unfinished", 0, rv[1]);
      w = LED;
      repeat (4) @(posedge CLK);
      chk("led blink", 1, LED != w);
    end else if (er) begin
      rc(`ETC_OFS_BAD, 32'(tot), "bad count");
      rd(`ETC_OFS_STATUS, rv);
      chk("fail flag", 1, rv[3]);
      @(posedge CLK);
      chk("led fail", 0, LED);
    end else begin
      rc(`ETC_OFS_GOOD, 32'(tot), "good count");
      rc(`ETC_OFS_WORDS, 32'(w), "rx words");
      rd(`ETC_OFS_CYCLES, rv);
      chk("cycles cover words", 1, rv >= w);
      rd(`ETC_OFS_STATUS, rv);
      chk("pass flag", 1, rv[2]);
      chk("led pass", 1, LED);
    end
    i_etc_mac_model.lens.delete();
    i_etc_mac_model.dq.delete();
  endtask
  // ==========================================================
  // Main sequence
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    void'($urandom(20));
    repeat (5) @(posedge CLK);
    chk("reset outputs", 0, {RDATA, TX_VALID, RX_READY, IRQ, LED});
    RST <= 1'b0;
    @(posedge CLK);
    rc(`ETC_OFS_TOTAL, 0, "total reset");
    rc(`ETC_OFS_RANDLEN, 0, "random length reset");
    rc(`ETC_OFS_MAXLEN, `ETC_RST_MAXLEN, "max length reset");
    rc(8'hfc, 0, "unmapped");
    wr(`ETC_OFS_RANDLEN, 32'hffff_ffff);
    rc(`ETC_OFS_RANDLEN, 1, "random length width");
    wr(`ETC_OFS_TOTAL, 32'hdead_beef);
    rc(`ETC_OFS_TOTAL, 32'hdead_beef, "total width");
    run(3, 2, 0, 0, 0, 0);
    chk("masked irq", 0, IRQ);
    rc(`ETC_OFS_INTSTS, 3, "event status");
    wr(`ETC_OFS_INTMSK, 7);
    @(posedge CLK);
    chk("unmasked irq", 1, IRQ);
    wr(`ETC_OFS_INTSTS, 3);
    rc(`ETC_OFS_INTSTS, 0, "status cleared");
    chk("irq cleared", 0, IRQ);
    run(2, 1, 0, 0, 1, 0);
    rc(`ETC_OFS_INTSTS, 7, "bad event");
    wr(`ETC_OFS_INTSTS, 4);
    rc(`ETC_OFS_INTSTS, 3, "partial clear");
    run(2, 3, 0, 0, 1, 1);
    run(1 + ($urandom % 4), 5, 1, 1, 0, 0);
    conclude();
  end
endmodule
`default_nettype wire
